// file: rtl/frt_pkg.sv
// Package for the free-running timer: register map, fields, reset values.
// Assumes a 32-bit classic Wishbone slave with word-aligned registers.
// Contract
// - Set compare A flag whenever the count equals compare A value.
// - Compare A flag clears only by reading it as 1 then writing 0.
// - Set compare B flag whenever the count equals compare B value.
// - Compare B flag clears only by reading it as 1 then writing 0.
// - Set wrap flag when the count rolls from all ones to zero.
// - Wrap flag clears only by reading it as 1 then writing 0.
// - Writing 1 to a status flag never sets or alters it.
// - Clear-on-match-A set: compare A match resets the count to zero.
// - Capture/clock control register is 8 bits, read/write, resets to zero.
// - Edge-select bits 7..4: 0 captures falling edge, 1 rising edge.
// - Buffer enable A makes capture C buffer A; B makes D buffer B.
// - Clock select 00/01/10 divides by 2/8/32; 11 counts external rising edges.
// - Buffered capture moves old primary value into buffer before loading count.
// - Buffer A on: channel C edge sets its flag without loading capture C.
package frt_pkg;
  localparam logic [7:0] FRT_ADR_STATUS   = 8'h00;
  localparam logic [7:0] FRT_ADR_CONTROL  = 8'h04;
  localparam logic [7:0] FRT_ADR_COUNT    = 8'h08;
  localparam logic [7:0] FRT_ADR_CMP_A    = 8'h0C;
  localparam logic [7:0] FRT_ADR_CMP_B    = 8'h10;
  localparam logic [7:0] FRT_ADR_CAP_A    = 8'h14;
  localparam logic [7:0] FRT_ADR_CAP_B    = 8'h18;
  localparam logic [7:0] FRT_ADR_CAP_C    = 8'h1C;
  localparam logic [7:0] FRT_ADR_CAP_D    = 8'h20;
  localparam logic [7:0] FRT_ADR_IRQ_STAT = 8'h24;
  localparam logic [7:0] FRT_ADR_IRQ_MASK = 8'h28;

  localparam int FRT_ST_CMP_A    = 3;
  localparam int FRT_ST_CMP_B    = 2;
  localparam int FRT_ST_WRAP     = 1;
  localparam int FRT_ST_CLR_A    = 0;
  localparam int FRT_CT_EDGE_HI  = 7;
  localparam int FRT_CT_BUF_A    = 3;
  localparam int FRT_CT_BUF_B    = 2;
  localparam int FRT_CT_CKS_HI   = 1;

  // Event bit layout of the interrupt status and mask registers
  localparam int FRT_EV_CMP_A    = 0;
  localparam int FRT_EV_CMP_B    = 1;
  localparam int FRT_EV_WRAP     = 2;
  localparam int FRT_EV_CAP_A    = 3;
  localparam int FRT_EV_CAP_B    = 4;
  localparam int FRT_EV_CAP_C    = 5;
  localparam int FRT_EV_CAP_D    = 6;
  localparam int FRT_EV_W        = 7;

  localparam logic [7:0]  FRT_STATUS_RST  = 8'h00;
  localparam logic [7:0]  FRT_CONTROL_RST = 8'h00;
  localparam logic [15:0] FRT_CMP_RST     = 16'hFFFF;
  localparam logic [15:0] FRT_COUNT_ALL1  = 16'hFFFF;

  localparam int FRT_DIV_2  = 2;
  localparam int FRT_DIV_8  = 8;
  localparam int FRT_DIV_32 = 32;

  typedef enum logic [1:0] {
    FRT_CK_DIV2 = 2'b00,
    FRT_CK_DIV8 = 2'b01,
    FRT_CK_DIV32 = 2'b10,
    FRT_CK_EXT  = 2'b11
  } frt_cks_e;
endpackage : frt_pkg

// file: rtl/frt_edge_if.sv
// Interface carrying one synchronised pin's edge events.
// Assumes single clock domain.
`timescale 1ns/1ps
interface frt_edge_if;
  logic rise;
  logic fall;
  modport src (output rise, output fall);
  modport dst (input rise, input fall);
endinterface : frt_edge_if

// file: rtl/frt_pin_edge.sv
// Two-flop synchroniser with rise and fall detection for one pin.
// Assumes pin is asynchronous to the system clock.
`timescale 1ns/1ps
module frt_pin_edge (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // Pin and events
  input  wire logic i_pin,
  frt_edge_if.src   o_edge
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= i_pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  assign o_edge.rise = s2_reg & ~s3_reg;
  assign o_edge.fall = ~s2_reg & s3_reg;
endmodule : frt_pin_edge

// file: rtl/frt_timer.sv
// Top of the free-running timer: Wishbone registers, counter, compare, capture.
// Assumes classic Wishbone, synchronous single-clock system at 200 MHz.
`timescale 1ns/1ps
module frt_timer
  import frt_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input  wire logic        I_MCLK,
  input  wire logic        I_RST,
  // Wishbone slave
  input  wire logic        I_WB_CYC,
  input  wire logic        I_WB_STB,
  input  wire logic        I_WB_WE,
  input  wire logic [7:0]  I_WB_ADR,
  input  wire logic [3:0]  I_WB_SEL,
  input  wire logic [31:0] I_WB_DAT,
  output logic      [31:0] O_WB_DAT,
  output logic             O_WB_ACK,
  // Pins
  input  wire logic        I_CAP_PIN_A,
  input  wire logic        I_CAP_PIN_B,
  input  wire logic        I_CAP_PIN_C,
  input  wire logic        I_CAP_PIN_D,
  input  wire logic        I_EXT_CLK_PIN,
  // Interrupt and capture strobes
  output logic             O_IRQ,
  output logic [3:0]       O_CAP_STB
);
  initial begin
    if (CNT_W != 16) $error("CNT_W must be 16");
  end

  logic [15:0] count_reg;
  logic [15:0] cmp_a_reg;
  logic [15:0] cmp_b_reg;
  logic [15:0] cap_reg [4];
  logic [7:0]  status_reg;
  logic [7:0]  control_reg;
  logic [2:0]  flag_seen_reg;
  logic [4:0]  pre_reg;
  logic [FRT_EV_W-1:0] irq_stat_reg;
  logic [FRT_EV_W-1:0] irq_mask_reg;
  logic [3:0]  cap_flag_reg;
  logic [3:0]  cap_stb_reg;
  logic        ack_reg;
  logic [31:0] rdat_reg;
  logic        irq_reg;

  // Pin synchronisers
  frt_edge_if edge_ext ();
  frt_edge_if edge_cap [4] ();
  logic [3:0] cap_pins;
  assign cap_pins = {I_CAP_PIN_D, I_CAP_PIN_C, I_CAP_PIN_B, I_CAP_PIN_A};

  frt_pin_edge u_ext (
    .i_clk  (I_MCLK),
    .i_rst  (I_RST),
    .i_pin  (I_EXT_CLK_PIN),
    .o_edge (edge_ext)
  );

  logic [3:0] cap_ev;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_cap
      frt_pin_edge u_cap (
        .i_clk  (I_MCLK),
        .i_rst  (I_RST),
        .i_pin  (cap_pins[g]),
        .o_edge (edge_cap[g])
      );
      // Edge select bit 7 is channel A down to bit 4 for D
      assign cap_ev[g] = control_reg[FRT_CT_EDGE_HI-g] ? edge_cap[g].rise : edge_cap[g].fall;
    end
  endgenerate

  // Bus access decode
  logic bus_req;
  logic wr_stb;
  logic rd_stb;
  assign bus_req = I_WB_CYC & I_WB_STB & ~ack_reg;
  assign wr_stb  = bus_req & I_WB_WE;
  assign rd_stb  = bus_req & ~I_WB_WE;

  logic wr_status;
  logic rd_status;
  assign wr_status = wr_stb & (I_WB_ADR == FRT_ADR_STATUS) & I_WB_SEL[0];
  assign rd_status = rd_stb & (I_WB_ADR == FRT_ADR_STATUS);

  // Count clock tick selection
  logic tick;
  always_comb begin
    case (frt_cks_e'(control_reg[FRT_CT_CKS_HI -: 2]))
      FRT_CK_DIV2:  tick = (pre_reg[0:0] == 1'(FRT_DIV_2 - 1));
      FRT_CK_DIV8:  tick = (pre_reg[2:0] == 3'(FRT_DIV_8 - 1));
      FRT_CK_DIV32: tick = (pre_reg == 5'(FRT_DIV_32 - 1));
      default:      tick = edge_ext.rise;
    endcase
  end

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      pre_reg <= 5'h00;
    end else begin
      pre_reg <= pre_reg + 5'h01;
    end
  end

  logic match_a;
  logic match_b;
  logic wrap;
  assign match_a = (count_reg == cmp_a_reg);
  assign match_b = (count_reg == cmp_b_reg);
  assign wrap    = tick & (count_reg == FRT_COUNT_ALL1);

  // Free-running counter
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      count_reg <= 16'h0000;
    end else if (wr_stb && I_WB_ADR == FRT_ADR_COUNT) begin
      count_reg <= I_WB_DAT[15:0];
    end else if (match_a && status_reg[FRT_ST_CLR_A]) begin
      count_reg <= 16'h0000;
    end else if (tick) begin
      count_reg <= count_reg + 16'h0001;
    end
  end

  // Compare values
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      cmp_a_reg <= FRT_CMP_RST;
      cmp_b_reg <= FRT_CMP_RST;
    end else if (wr_stb) begin
      if (I_WB_ADR == FRT_ADR_CMP_A) begin
        cmp_a_reg <= I_WB_DAT[15:0];
      end else if (I_WB_ADR == FRT_ADR_CMP_B) begin
        cmp_b_reg <= I_WB_DAT[15:0];
      end
    end
  end

  // Status flags: set wins over clear; clear needs prior read of 1
  logic [2:0] flag_set;
  logic [2:0] flag_clr;
  assign flag_set = {match_a, match_b, wrap};
  assign flag_clr = {3{wr_status}} & ~I_WB_DAT[FRT_ST_CMP_A:FRT_ST_WRAP] & flag_seen_reg;

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      status_reg <= FRT_STATUS_RST;
    end else begin
      // Written ones leave flags untouched
      status_reg[FRT_ST_CMP_A:FRT_ST_WRAP] <=
        flag_set | (status_reg[FRT_ST_CMP_A:FRT_ST_WRAP] & ~flag_clr);
      if (wr_status) begin
        status_reg[FRT_ST_CLR_A] <= I_WB_DAT[FRT_ST_CLR_A];
      end
    end
  end

  // Read-of-one tracking for the clear handshake
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      flag_seen_reg <= 3'b000;
    end else if (rd_status) begin
      flag_seen_reg <= status_reg[FRT_ST_CMP_A:FRT_ST_WRAP];
    end else if (wr_status) begin
      flag_seen_reg <= flag_seen_reg & I_WB_DAT[FRT_ST_CMP_A:FRT_ST_WRAP];
    end
  end

  // Control register
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      control_reg <= FRT_CONTROL_RST;
    end else if (wr_stb && I_WB_ADR == FRT_ADR_CONTROL && I_WB_SEL[0]) begin
      control_reg <= I_WB_DAT[7:0];
    end
  end

  // Capture registers and capture flags
  logic buf_a;
  logic buf_b;
  assign buf_a = control_reg[FRT_CT_BUF_A];
  assign buf_b = control_reg[FRT_CT_BUF_B];

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      for (int i = 0; i < 4; i++) begin
        cap_reg[i] <= 16'h0000;
      end
    end else begin
      if (cap_ev[0]) begin
        cap_reg[0] <= count_reg;
        if (buf_a) begin
          cap_reg[2] <= cap_reg[0];
        end
      end
      if (cap_ev[1]) begin
        cap_reg[1] <= count_reg;
        if (buf_b) begin
          cap_reg[3] <= cap_reg[1];
        end
      end
      if (cap_ev[2] && !buf_a) begin
        cap_reg[2] <= count_reg;
      end
      if (cap_ev[3] && !buf_b) begin
        cap_reg[3] <= count_reg;
      end
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      cap_flag_reg <= 4'h0;
      cap_stb_reg  <= 4'h0;
    end else begin
      cap_flag_reg <= cap_ev;
      cap_stb_reg  <= cap_ev;
    end
  end

  // Interrupt status and mask
  logic [FRT_EV_W-1:0] ev_vec;
  assign ev_vec = {cap_flag_reg, wrap, match_b, match_a};

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      irq_stat_reg <= '0;
    end else if (wr_stb && I_WB_ADR == FRT_ADR_IRQ_STAT && I_WB_SEL[0]) begin
      irq_stat_reg <= ev_vec | (irq_stat_reg & ~I_WB_DAT[FRT_EV_W-1:0]);
    end else begin
      irq_stat_reg <= ev_vec | irq_stat_reg;
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      irq_mask_reg <= '0;
    end else if (wr_stb && I_WB_ADR == FRT_ADR_IRQ_MASK && I_WB_SEL[0]) begin
      irq_mask_reg <= I_WB_DAT[FRT_EV_W-1:0];
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // Read data mux
  logic [31:0] rmux;
  always_comb begin
    rmux = 32'h0000_0000;
    if (I_WB_ADR == FRT_ADR_STATUS) begin
      rmux[7:0] = status_reg;
    end else if (I_WB_ADR == FRT_ADR_CONTROL) begin
      rmux[7:0] = control_reg;
    end else if (I_WB_ADR == FRT_ADR_COUNT) begin
      rmux[15:0] = count_reg;
    end else if (I_WB_ADR == FRT_ADR_CMP_A) begin
      rmux[15:0] = cmp_a_reg;
    end else if (I_WB_ADR == FRT_ADR_CMP_B) begin
      rmux[15:0] = cmp_b_reg;
    end else if (I_WB_ADR == FRT_ADR_CAP_A) begin
      rmux[15:0] = cap_reg[0];
    end else if (I_WB_ADR == FRT_ADR_CAP_B) begin
      rmux[15:0] = cap_reg[1];
    end else if (I_WB_ADR == FRT_ADR_CAP_C) begin
      rmux[15:0] = cap_reg[2];
    end else if (I_WB_ADR == FRT_ADR_CAP_D) begin
      rmux[15:0] = cap_reg[3];
    end else if (I_WB_ADR == FRT_ADR_IRQ_STAT) begin
      rmux[FRT_EV_W-1:0] = irq_stat_reg;
    end else if (I_WB_ADR == FRT_ADR_IRQ_MASK) begin
      rmux[FRT_EV_W-1:0] = irq_mask_reg;
    end
  end

  // Bus answer
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      ack_reg  <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= bus_req;
      if (rd_stb) begin
        rdat_reg <= rmux;
      end
    end
  end

  assign O_WB_ACK  = ack_reg;
  assign O_WB_DAT  = rdat_reg;
  assign O_IRQ     = irq_reg;
  assign O_CAP_STB = cap_stb_reg;
endmodule : frt_timer

// file: verif/frt_pin_model.sv
// Pin-side partner: four capture pins and the external count clock.
// Assumes the bench calls its tasks from the system clock domain.
`timescale 1ns/1ps
module frt_pin_model (
  // Clock
  input  wire logic       i_clk,
  // Pins
  output logic      [3:0] o_cap,
  output logic            o_ext
);
  initial begin
    o_cap = 4'h0;
    o_ext = 1'b0;
  end
  // Toggle one capture pin, then hold it
  task automatic flip(input int ch);
    @(posedge i_clk) o_cap[ch] <= ~o_cap[ch];
    repeat (10) @(posedge i_clk);
  endtask : flip
  // Burst of external clock pulses, low between bursts
  task automatic burst(input int n);
    repeat (n) begin
      @(posedge i_clk) o_ext <= 1'b1;
      repeat (3) @(posedge i_clk);
      o_ext <= 1'b0;
      repeat (3) @(posedge i_clk);
    end
  endtask : burst
endmodule : frt_pin_model

// file: verif/frt_timer_assertions.sv
// Checker for the timer's bus answers and capture edge selection.
// Assumes it is bound to the timer top and sees only its ports.
`timescale 1ns/1ps
module frt_timer_chk
  import frt_pkg::*;
(
  input wire logic        I_MCLK,
  input wire logic        I_RST,
  input wire logic        I_WB_CYC,
  input wire logic        I_WB_STB,
  input wire logic        I_WB_WE,
  input wire logic [7:0]  I_WB_ADR,
  input wire logic [3:0]  I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  input wire logic [31:0] O_WB_DAT,
  input wire logic        O_WB_ACK,
  input wire logic        I_CAP_PIN_A,
  input wire logic        I_CAP_PIN_B,
  input wire logic [3:0]  O_CAP_STB
);
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (I_RST);
  logic       req;
  logic [7:0] ctrl_reg;
  assign req = I_WB_CYC && I_WB_STB && !O_WB_ACK;
  // Shadow of the control register
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      ctrl_reg <= 8'h00;
    end else if (req && I_WB_WE && I_WB_SEL[0] && I_WB_ADR == FRT_ADR_CONTROL) begin
      ctrl_reg <= I_WB_DAT[7:0];
    end
  end
  a_ack_next_cycle: assert property (req |=> O_WB_ACK)
    else $error("ack missing after request");
  a_ack_one_pulse: assert property (O_WB_ACK |=> !O_WB_ACK)
    else $error("ack longer than one cycle");
  a_ack_no_request: assert property (!(I_WB_CYC && I_WB_STB) |=> !O_WB_ACK)
    else $error("ack without request");
  a_ctrl_read_back: assert property (req && !I_WB_WE && I_WB_ADR == FRT_ADR_CONTROL |=>
    O_WB_DAT == {24'h000000, ctrl_reg})
    else $error("control read mismatch");
  a_unmapped_zero: assert property (req && !I_WB_WE && I_WB_ADR > FRT_ADR_IRQ_MASK |=>
    O_WB_DAT == 32'h00000000)
    else $error("unmapped read not zero");
  a_rise_a_seen: assert property ($rose(I_CAP_PIN_A) && ctrl_reg[7] |-> ##[1:6] O_CAP_STB[0])
    else $error("rising edge A missed");
  a_fall_a_seen: assert property ($fell(I_CAP_PIN_A) && !ctrl_reg[7] |-> ##[1:6] O_CAP_STB[0])
    else $error("falling edge A missed");
  a_rise_b_seen: assert property ($rose(I_CAP_PIN_B) && ctrl_reg[6] |-> ##[1:6] O_CAP_STB[1])
    else $error("rising edge B missed");
  a_rise_b_ignored: assert property ($rose(I_CAP_PIN_B) && !ctrl_reg[6] |=> (!O_CAP_STB[1]) [*6])
    else $error("unselected edge B captured");
endmodule : frt_timer_chk

bind frt_timer frt_timer_chk u_chk (
  .I_MCLK(I_MCLK),
  .I_RST(I_RST),
  .I_WB_CYC(I_WB_CYC),
  .I_WB_STB(I_WB_STB),
  .I_WB_WE(I_WB_WE),
  .I_WB_ADR(I_WB_ADR),
  .I_WB_SEL(I_WB_SEL),
  .I_WB_DAT(I_WB_DAT),
  .O_WB_DAT(O_WB_DAT),
  .O_WB_ACK(O_WB_ACK),
  .I_CAP_PIN_A(I_CAP_PIN_A),
  .I_CAP_PIN_B(I_CAP_PIN_B),
  .O_CAP_STB(O_CAP_STB)
);

// file: verif/tb_free_run_timer_flags_and_control.sv
// Bench for the timer: registers, flags, clock select, capture, interrupt.
// Assumes the pin model drives the capture pins and external clock.
`timescale 1ns/1ps
module tb_free_run_timer_flags_and_control
  import frt_pkg::*;
;
  logic        clk, rst, cyc, stb, we, ack, irq;
  logic [7:0]  adr;
  logic [31:0] dat, rdat;
  logic [3:0]  cap, cstb;
  logic        ext;
  logic [3:0]  sel, sel_v;
  int          stb_cnt[4];
  int          err_count = 0;
  int          checked = 0;
  int          cyc_cnt = 0;
  frt_pin_model u_pins (.i_clk(clk), .o_cap(cap), .o_ext(ext));
  frt_timer u_dut (
    .I_MCLK(clk), .I_RST(rst), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
    .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(dat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
    .I_CAP_PIN_A(cap[0]), .I_CAP_PIN_B(cap[1]), .I_CAP_PIN_C(cap[2]), .I_CAP_PIN_D(cap[3]),
    .I_EXT_CLK_PIN(ext), .O_IRQ(irq), .O_CAP_STB(cstb)
  );
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Count capture strobes per channel
  always @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      if (cstb[i] === 1'b1) stb_cnt[i] <= stb_cnt[i] + 1;
    end
  end
  // Cut a hang short
  always @(posedge clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      err_count++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Classic single cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= sel_v;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask : rc
  task automatic t_regs();
    rc(FRT_ADR_CONTROL, 32'h0);
    rc(FRT_ADR_STATUS, 32'h0);
    wr(FRT_ADR_CONTROL, 32'hA6);
    rc(FRT_ADR_CONTROL, 32'hA6);
    sel_v = 4'hE;
    wr(FRT_ADR_CONTROL, 32'h55);
    sel_v = 4'hF;
    rc(FRT_ADR_CONTROL, 32'hA6);
    rc(8'h3C, 32'h0);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_flags();
    wr(FRT_ADR_CONTROL, 32'h0);
    wr(FRT_ADR_CMP_A, 32'h40);
    wr(FRT_ADR_CMP_B, 32'h41);
    wr(FRT_ADR_COUNT, 32'h0);
    repeat (200) @(posedge clk);
    wr(FRT_ADR_STATUS, 32'h0);
    rc(FRT_ADR_STATUS, 32'h0C);
    wr(FRT_ADR_STATUS, 32'h0C);
    rc(FRT_ADR_STATUS, 32'h0C);
    wr(FRT_ADR_STATUS, 32'h0);
    rc(FRT_ADR_STATUS, 32'h0);
    wr(FRT_ADR_COUNT, 32'hFFF0);
    repeat (60) @(posedge clk);
    rc(FRT_ADR_STATUS, 32'h02);
    wr(FRT_ADR_STATUS, 32'h0);
    rc(FRT_ADR_STATUS, 32'h0);
    $display("t_flags done");
  endtask : t_flags
  task automatic t_clear();
    logic [31:0] q;
    wr(FRT_ADR_CMP_A, 32'h10);
    wr(FRT_ADR_STATUS, 32'h01);
    wr(FRT_ADR_COUNT, 32'h0);
    repeat (100) @(posedge clk);
    wb(1'b0, FRT_ADR_COUNT, 32'h0, q);
    chk(32'(q <= 32'h10), 32'h1);
    wr(FRT_ADR_STATUS, 32'h0);
    $display("t_clear done");
  endtask : t_clear
  task automatic t_clksel();
    logic [31:0] q;
    int          dv[3];
    dv = '{FRT_DIV_2, FRT_DIV_8, FRT_DIV_32};
    for (int k = 0; k < 3; k++) begin
      wr(FRT_ADR_CONTROL, 32'(k));
      wr(FRT_ADR_COUNT, 32'h0);
      repeat (320) @(posedge clk);
      wb(1'b0, FRT_ADR_COUNT, 32'h0, q);
      chk(32'(q >= 320 / dv[k] && q <= 320 / dv[k] + 3), 32'h1);
    end
    wr(FRT_ADR_CONTROL, 32'h03);
    wr(FRT_ADR_COUNT, 32'h0);
    u_pins.burst(10);
    repeat (5) @(posedge clk);
    rc(FRT_ADR_COUNT, 32'hA);
    $display("t_clksel done");
  endtask : t_clksel
  task automatic t_capture();
    logic [31:0] a1, q;
    wr(FRT_ADR_IRQ_STAT, 32'hFF);
    wr(FRT_ADR_CONTROL, 32'hC8);
    wr(FRT_ADR_IRQ_MASK, 32'h08);
    repeat (3) @(posedge clk);
    chk(32'(irq), 32'h0);
    u_pins.flip(0);
    chk(32'(irq), 32'h1);
    wb(1'b0, FRT_ADR_CAP_A, 32'h0, a1);
    u_pins.flip(0);
    u_pins.flip(0);
    rc(FRT_ADR_CAP_C, a1);
    wb(1'b0, FRT_ADR_CAP_A, 32'h0, q);
    chk(32'(q > a1), 32'h1);
    u_pins.flip(2);
    u_pins.flip(2);
    rc(FRT_ADR_CAP_C, a1);
    u_pins.flip(1);
    wr(FRT_ADR_CONTROL, 32'h0);
    u_pins.flip(1);
    u_pins.flip(1);
    u_pins.flip(0);
    wr(FRT_ADR_IRQ_STAT, 32'hFF);
    repeat (3) @(posedge clk);
    chk(32'(irq), 32'h0);
    chk(32'(stb_cnt[0]), 32'h3);
    chk(32'(stb_cnt[1]), 32'h2);
    chk(32'(stb_cnt[2]), 32'h1);
    chk(32'(stb_cnt[3]), 32'h0);
    $display("t_capture done");
  endtask : t_capture
  initial begin
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we  = 1'b0;
    adr = 8'h00;
    dat = 32'h0;
    sel = 4'hF;
    sel_v = 4'hF;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_flags();
    t_clear();
    t_clksel();
    t_capture();
    wrap_up();
  end
endmodule : tb_free_run_timer_flags_and_control
